/* tile_pkg.sv */
// shared constants and types for the programmable logic tile
package tile_pkg;

  // apb address width and register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] LUT_INIT_BASE = 8'h00;
  localparam logic [7:0] MODE_OFFSET = 8'h20;
  localparam logic [7:0] STATUS_OFFSET = 8'h24;

  // tile shape
  localparam int NUM_SLICES = 4;
  localparam int REG_SLICES = 3;
  localparam int NUM_LUTS = 8;
  localparam int LUT_BITS = 16;

  // reset values
  localparam logic [15:0] LUT_RESET = 16'h0000;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_MASK = 32'h0003_FFFF;

  // mode register fields; slice s mode sits in bits 2s+1:2s
  localparam int MODE_OP_LSB = 8;
  localparam int MODE_LSR_SYNC = 12;
  localparam int MODE_SR_VALUE = 13;
  localparam int MODE_CLK_NEG = 14;
  localparam int MODE_LEVEL = 15;
  localparam int MODE_PDP = 16;
  localparam int MODE_CLK_SHARED = 17;

  // slice operating modes
  typedef enum logic [1:0] {MODE_LOGIC, MODE_RIPPLE, MODE_RAM, MODE_ROM}
    slice_mode_t;

  // ripple mode operations
  typedef enum logic [3:0] {OP_ADD, OP_SUB, OP_ADDSUB, OP_UP, OP_DOWN,
    OP_UPDOWN, OP_GE, OP_NE, OP_LE, OP_MULT} ripple_op_t;

endpackage

/* lut_slice.sv */
// one slice: two lut4s, lut5 mux and 2-bit ripple arithmetic
`timescale 1ns/1ps
module lut_slice
(
  // configuration
  input wire logic [15:0] initZero,
  input wire logic [15:0] initOne,
  input wire logic rippleOn,
  input wire tile_pkg::ripple_op_t op,
  // routing and chain inputs
  input wire logic [3:0] inZero,
  input wire logic [3:0] inOne,
  input wire logic selIn,
  input wire logic [1:0] state,
  input wire logic carryIn,
  // results
  output logic lutOutZero,
  output logic lutOutOne,
  output logic fiveMux,
  output logic [1:0] sum,
  output logic carryGen,
  output logic carryProp,
  output logic carryOut
);
  logic [1:0] opA;
  logic [1:0] opB;
  logic [1:0] x;
  logic [1:0] y;
  logic [1:0] g;
  logic [1:0] p;
  logic c1;
  logic isNe;

  // lookup of both tables, any function of four inputs
  assign lutOutZero = initZero[inZero];
  assign lutOutOne = initOne[inOne];
  assign fiveMux = selIn ? lutOutOne : lutOutZero;

  // operand bits taken from the lut inputs
  assign opA = {inOne[0], inZero[0]};
  assign opB = {inOne[1], inZero[1]};

  // operand steering per ripple operation
  always_comb
  begin
    x = opA;
    y = opB;
    case (op)
      tile_pkg::OP_SUB: y = ~opB;
      tile_pkg::OP_ADDSUB: y = selIn ? ~opB : opB;
      tile_pkg::OP_UP:
      begin
        x = state;
        y = 2'h0;
      end
      tile_pkg::OP_DOWN:
      begin
        x = state;
        y = 2'h3;
      end
      tile_pkg::OP_UPDOWN:
      begin
        x = state;
        y = selIn ? 2'h0 : 2'h3;
      end
      tile_pkg::OP_GE: y = ~opB;
      tile_pkg::OP_LE:
      begin
        x = opB;
        y = ~opA;
      end
      tile_pkg::OP_MULT:
      begin
        x = opB;
        y = opA & {2{selIn}};
      end
      default: y = opB;
    endcase
  end

  // generate and propagate form of the 2-bit carry
  assign isNe = (op == tile_pkg::OP_NE);
  assign g = x & y;
  assign p = x ^ y;
  assign c1 = g[0] | (p[0] & carryIn);
  assign sum = p ^ {c1, carryIn};
  assign carryGen = isNe ? |(opA ^ opB) : g[1] | (p[1] & g[0]);
  assign carryProp = isNe ? 1'b1 : &p;
  assign carryOut = rippleOn & (carryGen | (carryProp & carryIn));

endmodule

/* programmable_logic_tile.sv */
// programmable logic tile: four slices, registers, lut ram and apb config
`timescale 1ns/1ps
// Behaviour
// - four slices numbered 0 to 3, two lut4s each, all joined by routing
// - tile has 50 routing inputs and 23 routing outputs
// - slices 0 to 2 feed two registers; slice 3 has none
// - only the ram-capable variant gives ram mode in slices 0 to 2
// - each lut covers all 16 input cases; two luts make a lut5
// - lut6, lut7 and lut8 built by chaining slices; lut8 spans two tiles
// - set/reset sync or async, clock select, chip select for wider ram
// - slice registers take either clock polarity, edge or level sensitive
// - slices 0 to 2: 13 routing inputs plus carry in, carry out
// - slice 3 has 10 routing inputs, four outputs, no carry
// - slice 2 drives ram clock, write enable, data and 4-bit address
// - outputs: lut bypass, registers, lut5 mux and wide mux
// - carry enters from neighbour; slice 2 drives tile carry out
// - ripple: 2-bit add, subtract, dynamic add/sub, up and down count
// - up/down counters with async clear and sync preload
// - compare greater-equal, not-equal, less-equal; multiplier building block
// - fast carry form gives per-slice generate and propagate
// - 16x4 single-port ram from slices 0 and 1, slice 2 controls
// - 16x2 pseudo dual-port ram: read-write slice plus read-only companion
// - either ram form occupies three slices
// - lut memory contents set at configuration time
// - all four slices run rom mode with preloaded contents
module programmable_logic_tile
#(
  parameter bit RAM_CAPABLE = 1'b1
)
(
  // system clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb configuration port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tile_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // routing inputs
  input wire logic [31:0] lutDataIn,
  input wire logic [3:0] multipurposeInZero,
  input wire logic [3:0] multipurposeInOne,
  input wire logic [2:0] sliceClockEnable,
  input wire logic [2:0] localSetReset,
  input wire logic [2:0] sliceClock,
  input wire logic fastCarryIn,
  // routing outputs
  output logic [3:0] lutBypassOutZero,
  output logic [3:0] lutBypassOutOne,
  output logic [2:0] registerOutZero,
  output logic [2:0] registerOutOne,
  output logic [3:0] fiveInputMuxOut,
  output logic [3:0] wideMuxOut,
  output logic fastCarryOut
);
  // lut contents and mode register
  logic [7:0][15:0] lutMem;
  logic [31:0] modeReg;
  tile_pkg::slice_mode_t sliceMode [4];
  tile_pkg::ripple_op_t rippleOp;
  logic lsrSync;
  logic srValue;
  logic clkNeg;
  logic levelSens;
  logic pdpMode;
  logic clkShared;

  // slice results
  logic [7:0][3:0] lutAddr;
  logic [3:0] f0;
  logic [3:0] f1;
  logic [3:0] five_input_mux_out;
  logic [3:0] wide_mux_out;
  logic [3:0] gen;
  logic [3:0] prop;
  logic [4:0] chain;
  logic [3:0][1:0] sum;
  logic [2:0][1:0] qReg;
  logic [2:0][1:0] next_q;

  // slice clocking
  logic [2:0] activeLvl;
  logic [2:0] prevActive;
  logic [2:0] clkEdge;
  logic [2:0] clkEvent;

  // lut ram control
  logic ramMode;
  logic ramWrite;
  logic [3:0] ramAddr;
  logic [3:0] ramData;
  logic chipSel;

  // apb handshake
  logic setup;
  logic access;
  logic apbWrite;
  logic [2:0] apbIndex;

  // mode register fields
  always_comb
  begin
    for (int s = 0; s < tile_pkg::NUM_SLICES; s++)
      sliceMode[s] = tile_pkg::slice_mode_t'(modeReg[2*s +: 2]);
  end
  assign rippleOp = tile_pkg::ripple_op_t'(modeReg[tile_pkg::MODE_OP_LSB +: 4]);
  assign lsrSync = modeReg[tile_pkg::MODE_LSR_SYNC];
  assign srValue = modeReg[tile_pkg::MODE_SR_VALUE];
  assign clkNeg = modeReg[tile_pkg::MODE_CLK_NEG];
  assign levelSens = modeReg[tile_pkg::MODE_LEVEL];
  assign pdpMode = modeReg[tile_pkg::MODE_PDP];
  assign clkShared = modeReg[tile_pkg::MODE_CLK_SHARED];

  // slice 2 supplies address, data, enable and chip select to the ram
  assign ramMode = RAM_CAPABLE && sliceMode[0] == tile_pkg::MODE_RAM;
  assign ramAddr = lutDataIn[19:16];
  assign ramData = lutDataIn[23:20];
  assign chipSel = multipurposeInZero[2];
  assign ramWrite = ramMode & clkEdge[2] & localSetReset[2] & chipSel;

  // lut read addresses; dual-port read-write slice reads at write address
  always_comb
  begin
    for (int i = 0; i < tile_pkg::NUM_LUTS; i++)
      lutAddr[i] = lutDataIn[4*i +: 4];
    if (ramMode && pdpMode)
    begin
      lutAddr[0] = ramAddr;
      lutAddr[1] = ramAddr;
    end
  end

  // four slices; slices 0 to 2 chained through the fast carry
  assign chain[0] = fastCarryIn;
  genvar gs;
  generate
    for (gs = 0; gs < tile_pkg::NUM_SLICES; gs++)
    begin : g_slice
      logic [1:0] stateBits;
      logic rippleOn;
      assign stateBits = (gs < tile_pkg::REG_SLICES) ? qReg[gs % 3] : 2'h0;
      // slice 3 never joins the carry chain
      assign rippleOn = (gs < tile_pkg::REG_SLICES) &&
        sliceMode[gs] == tile_pkg::MODE_RIPPLE;
      lut_slice u_slice
      (
        .initZero(lutMem[2*gs]),
        .initOne(lutMem[2*gs+1]),
        .rippleOn(rippleOn),
        .op(rippleOp),
        .inZero(lutAddr[2*gs]),
        .inOne(lutAddr[2*gs+1]),
        .selIn(multipurposeInZero[gs]),
        .state(stateBits),
        .carryIn(chain[gs]),
        .lutOutZero(f0[gs]),
        .lutOutOne(f1[gs]),
        .fiveMux(five_input_mux_out[gs]),
        .sum(sum[gs]),
        .carryGen(gen[gs]),
        .carryProp(prop[gs]),
        .carryOut(chain[gs+1])
      );
    end
  endgenerate

  // wide function muxes: lut6 pairs, lut7, lut8 with neighbour's lut7
  assign wide_mux_out[0] = multipurposeInOne[0] ? five_input_mux_out[1] : five_input_mux_out[0];
  assign wide_mux_out[2] = multipurposeInOne[2] ? five_input_mux_out[3] : five_input_mux_out[2];
  assign wide_mux_out[1] = multipurposeInOne[1] ? wide_mux_out[2] : wide_mux_out[0];
  assign wide_mux_out[3] = multipurposeInOne[3] ? lutDataIn[31] : wide_mux_out[1];

  // active clock level per register slice, optional shared clock
  always_comb
  begin
    for (int s = 0; s < tile_pkg::REG_SLICES; s++)
      activeLvl[s] = (clkShared ? sliceClock[0] : sliceClock[s]) ^ clkNeg;
  end
  assign clkEdge = activeLvl & ~prevActive;
  assign clkEvent = levelSens ? activeLvl : clkEdge;

  // previous clock level for edge detection
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      prevActive <= 3'h0;
    else
      prevActive <= activeLvl;
  end

  // register data: sum in ripple mode, lut outputs otherwise
  always_comb
  begin
    for (int s = 0; s < tile_pkg::REG_SLICES; s++)
      next_q[s] = (sliceMode[s] == tile_pkg::MODE_RIPPLE) ? sum[s]
        : {f1[s], f0[s]};
  end

  // slice registers with set/reset, preload and clock enable
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      qReg <= '0;
    else
      for (int s = 0; s < tile_pkg::REG_SLICES; s++)
      begin
        if (localSetReset[s] && !lsrSync)
          qReg[s] <= {2{srValue}};
        else if (clkEvent[s])
        begin
          if (localSetReset[s] && sliceMode[s] == tile_pkg::MODE_RIPPLE &&
            rippleOp inside {tile_pkg::OP_UP, tile_pkg::OP_DOWN,
            tile_pkg::OP_UPDOWN})
            qReg[s] <= {multipurposeInOne[s], multipurposeInZero[s]};
          else if (localSetReset[s])
            qReg[s] <= {2{srValue}};
          else if (sliceClockEnable[s])
            qReg[s] <= next_q[s];
        end
      end
  end

  // apb phases
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign apbWrite = access & pwrite;
  assign apbIndex = paddr[4:2];

  // lut contents: configuration writes win over ram writes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      lutMem <= {tile_pkg::NUM_LUTS{tile_pkg::LUT_RESET}};
    else
      for (int i = 0; i < tile_pkg::NUM_LUTS; i++)
      begin
        if (apbWrite && paddr < tile_pkg::MODE_OFFSET &&
          paddr[1:0] == 2'h0 && apbIndex == i[2:0])
          lutMem[i] <= pwdata[15:0];
        else if (ramWrite && i < 2)
          lutMem[i][ramAddr] <= ramData[i[1:0]];
        else if (ramWrite && i < 4)
          lutMem[i][ramAddr] <= ramData[i[1:0] ^ {pdpMode, 1'b0}];
      end
  end

  // mode register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      modeReg <= tile_pkg::MODE_RESET;
    else if (apbWrite && paddr == tile_pkg::MODE_OFFSET)
      modeReg <= pwdata & tile_pkg::MODE_MASK;
  end

  // apb answer: one access cycle, data and error set in setup
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      if (setup)
      begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
        if (paddr[1:0] != 2'h0)
          pslverr <= 1'b1;
        else if (paddr < tile_pkg::MODE_OFFSET)
          prdata <= {16'h0000, lutMem[apbIndex]};
        else if (paddr == tile_pkg::MODE_OFFSET)
          prdata <= modeReg;
        else if (paddr == tile_pkg::STATUS_OFFSET)
          prdata <= {19'h0, prop[2:0], gen[2:0], chain[3], qReg};
        else
          pslverr <= 1'b1;
      end
    end
  end

  // routing outputs captured every clock
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lutBypassOutZero <= 4'h0;
      lutBypassOutOne <= 4'h0;
      fiveInputMuxOut <= 4'h0;
      wideMuxOut <= 4'h0;
      fastCarryOut <= 1'b0;
    end
    else
    begin
      lutBypassOutZero <= f0;
      lutBypassOutOne <= f1;
      fiveInputMuxOut <= five_input_mux_out;
      wideMuxOut <= wide_mux_out;
      fastCarryOut <= chain[3];
    end
  end

  // register outputs straight from the slice registers
  always_comb
  begin
    for (int s = 0; s < tile_pkg::REG_SLICES; s++)
    begin
      registerOutZero[s] = qReg[s][0];
      registerOutOne[s] = qReg[s][1];
    end
  end

  // apb checks
  a_apb_ready: assert property (@(posedge clk) disable iff (reset) // APB
    setup |=> pready ##1 !pready)
    else $error("setup not answered in one access cycle");
  a_unmapped_err: assert property (@(posedge clk) disable iff (reset)
    setup && paddr > tile_pkg::STATUS_OFFSET |=> pslverr && pready)
    else $error("unmapped address without error");

  // configuration and memory checks
  a_lut_init: assert property (@(posedge clk) disable iff (reset)
    apbWrite && paddr < tile_pkg::MODE_OFFSET && paddr[1:0] == 2'h0
    |=> lutMem[$past(apbIndex)] == $past(pwdata[15:0]))
    else $error("lut contents not loaded by write");
  a_ram_write: assert property (@(posedge clk) disable iff (reset)
    ramWrite && !(apbWrite && paddr < tile_pkg::MODE_OFFSET)
    |=> lutMem[0][$past(ramAddr)] == $past(ramData[0]))
    else $error("ram write lost");
  a_rom_hold: assert property (@(posedge clk) disable iff (reset)
    sliceMode[0] == tile_pkg::MODE_ROM && !apbWrite |=> $stable(lutMem[0]))
    else $error("rom contents changed");

  // register and output checks
  a_ce_hold: assert property (@(posedge clk) disable iff (reset)
    !sliceClockEnable[0] && !localSetReset[0] |=> $stable(qReg[0]))
    else $error("register changed without clock enable");
  a_async_clear: assert property (@(posedge clk) disable iff (reset)
    localSetReset[1] && !lsrSync |=> qReg[1] == {2{$past(srValue)}})
    else $error("async set/reset not applied");
  a_carry_out: assert property (@(posedge clk) disable iff (reset)
    sliceMode[2] != tile_pkg::MODE_RIPPLE |=> !fastCarryOut)
    else $error("carry out without ripple slice 2");
  a_five_mux: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> fiveInputMuxOut[1] == ($past(multipurposeInZero[1]) ?
    lutBypassOutOne[1] : lutBypassOutZero[1]))
    else $error("lut5 mux mismatch");
  a_bypass_lut: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> lutBypassOutZero[3] == $past(lutMem[6][lutDataIn[27:24]]))
    else $error("lut bypass output mismatch");

  // main scenarios
  c_ram_write: cover property (@(posedge clk) disable iff (reset) ramWrite);
  c_carry_out: cover property (@(posedge clk) disable iff (reset)
    fastCarryOut);
  c_reg_load: cover property (@(posedge clk) disable iff (reset)
    clkEvent[0] && sliceClockEnable[0]);
  c_apb_read: cover property (@(posedge clk) disable iff (reset)
    access && !pwrite);

endmodule

/* routing_partner.sv */
// routing fabric and neighbour tile model feeding slice clocks and carry
`timescale 1ns/1ps
module routing_partner
(
  // system clock and reset
  input wire logic clk,
  input wire logic reset,
  // requests from the bench
  input wire logic [2:0] pulseReq,
  input wire logic neighbourCarry,
  // toward the tile
  output logic [2:0] sliceClock,
  output logic fastCarryIn
);
  // slice clocks rest low, one high cycle per request
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      sliceClock <= 3'h0;
    else
      sliceClock <= pulseReq;
  end

  // carry handed on from the neighbouring tile
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      fastCarryIn <= 1'b0;
    else
      fastCarryIn <= neighbourCarry;
  end
endmodule

/* programmable_logic_tile_test.sv */
// self-checking bench for the programmable logic tile
`timescale 1ns/1ps
module programmable_logic_tile_test;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [tile_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, lutDataIn, rd;
  logic [3:0] multipurposeInZero, multipurposeInOne;
  logic [2:0] sliceClockEnable, localSetReset, sliceClock, pulseReq;
  logic fastCarryIn, neighbourCarry, fastCarryOut, e;
  logic [3:0] lutBypassOutZero, lutBypassOutOne, fiveInputMuxOut, wideMuxOut;
  logic [2:0] registerOutZero, registerOutOne;
  logic [15:0] pat [8];
  logic [3:0] f0, f1, fm, w, n4, ramAddr [3], ramData [3];
  logic [1:0] a, b;
  tile_pkg::ripple_op_t ops [6];
  logic [5:0] cin;
  int badCount, nChecks;

  // device under test and far side model
  programmable_logic_tile #(.RAM_CAPABLE(1'b1)) programmable_logic_tile_inst
  (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .lutDataIn, .multipurposeInZero, .multipurposeInOne,
    .sliceClockEnable, .localSetReset, .sliceClock, .fastCarryIn,
    .lutBypassOutZero, .lutBypassOutOne, .registerOutZero, .registerOutOne,
    .fiveInputMuxOut, .wideMuxOut, .fastCarryOut
  );
  routing_partner routing_partner_inst
  (
    .clk, .reset, .pulseReq, .neighbourCarry, .sliceClock, .fastCarryIn
  );

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    nChecks++;
    if (got !== exp)
    begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      badCount++;
    end
  end
  endtask

  // counts and verdict
  task automatic summarize();
  begin
    $display("checks=%0d mismatches=%0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  // one apb transfer, bounded wait for pready
  task automatic apb(input logic wr, input logic [7:0] ad,
    input logic [31:0] d, output logic [31:0] q, output logic se);
    int n;
  begin
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // pready, read data and error taken at the same rising edge
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        badCount++;
        summarize();
      end
      @(posedge clk);
    end
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, rd, err);
  endtask

  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
  begin
    apb(1'b0, ad, 32'h0, rd, err);
    chk(rd, exp);
  end
  endtask

  // one slice clock event through the partner
  task automatic pulse(input logic [2:0] which);
  begin
    @(posedge clk);
    pulseReq <= which;
    @(posedge clk);
    pulseReq <= 3'h0;
    repeat (3) @(posedge clk);
    #1;
  end
  endtask

  // main sequence
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    lutDataIn = 32'h0;
    multipurposeInZero = 4'h0;
    multipurposeInOne = 4'h0;
    sliceClockEnable = 3'h0;
    localSetReset = 3'h0;
    pulseReq = 3'h0;
    neighbourCarry = 1'b0;
    badCount = 0;
    nChecks = 0;
    pat = '{16'h8000, 16'hFFFE, 16'h6996, 16'h0001, 16'hA5C3, 16'h1234,
      16'hF0F0, 16'h7FFF};
    ops = '{tile_pkg::OP_ADD, tile_pkg::OP_SUB, tile_pkg::OP_GE,
      tile_pkg::OP_LE, tile_pkg::OP_NE, tile_pkg::OP_ADDSUB};
    cin = 6'b101110;
    ramAddr = '{4'h0, 4'hF, 4'h7};
    ramData = '{4'h5, 4'hA, 4'hC};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk({lutBypassOutZero, lutBypassOutOne, fiveInputMuxOut, wideMuxOut}, 0);
    chk({registerOutZero, registerOutOne, fastCarryOut}, 32'h0);
    for (int i = 0; i < 8; i++)
      rdchk(8'(4 * i), 32'h0);
    rdchk(tile_pkg::MODE_OFFSET, tile_pkg::MODE_RESET);
    wr(tile_pkg::MODE_OFFSET, 32'hFFFF_FFFF);
    rdchk(tile_pkg::MODE_OFFSET, tile_pkg::MODE_MASK);
    wr(tile_pkg::MODE_OFFSET, 32'h0);
    apb(1'b1, 8'h28, 32'h1, rd, err);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h02, 32'h0, rd, err);
    chk({err, rd[30:0]}, 32'h8000_0000);
    $display("test registers done");
    // every lut over all input cases, lut5 to lut8 muxes
    for (int i = 0; i < 8; i++)
      wr(8'(4 * i), {16'hABCD, pat[i]});
    rdchk(8'h04, {16'h0, pat[1]});
    for (int n = 0; n < 16; n++)
    begin
      n4 = 4'(n);
      @(posedge clk);
      lutDataIn <= {8{n4}};
      multipurposeInZero <= n4 ^ 4'h5;
      multipurposeInOne <= ~n4;
      for (int s = 0; s < 4; s++)
      begin
        f0[s] = pat[2 * s][n];
        f1[s] = pat[2 * s + 1][n];
        fm[s] = (n4[s] ^ (s == 0 || s == 2)) ? f1[s] : f0[s];
      end
      w[0] = ~n4[0] ? fm[1] : fm[0];
      w[2] = ~n4[2] ? fm[3] : fm[2];
      w[1] = ~n4[1] ? w[2] : w[0];
      w[3] = ~n4[3] ? n4[3] : w[1];
      repeat (2) @(posedge clk);
      #1;
      chk({lutBypassOutZero, lutBypassOutOne}, {24'h0, f0, f1});
      chk({fiveInputMuxOut, wideMuxOut}, {24'h0, fm, w});
    end
    pulse(3'h7);
    chk({registerOutZero, registerOutOne}, 32'h0);
    sliceClockEnable <= 3'h7;
    pulse(3'h7);
    chk({registerOutZero, registerOutOne}, {f0[2:0], f1[2:0]});
    wr(tile_pkg::MODE_OFFSET, 32'h2000);
    sliceClockEnable <= 3'h0;
    localSetReset <= 3'h7;
    repeat (3) @(posedge clk);
    #1;
    chk({registerOutZero, registerOutOne}, 32'h3F);
    $display("test logic done");
    // ripple add, subtract and compares over all 2-bit operands
    @(posedge clk);
    localSetReset <= 3'h0;
    sliceClockEnable <= 3'h7;
    for (int k = 0; k < 6; k++)
    begin
      // dynamic add/sub runs slices 0 to 2 as subtract
      multipurposeInZero <= (k == 5) ? 4'h7 : 4'h0;
      wr(tile_pkg::MODE_OFFSET, 32'h15 | (32'(ops[k]) << 8));
      for (int v = 0; v < 16; v++)
      begin
        a = v[3:2];
        b = v[1:0];
        @(posedge clk);
        neighbourCarry <= cin[k];
        lutDataIn <= {10'h0, b[1], a[1], 2'h0, b[0], a[0], 16'h0};
        e = (k == 0) ? (a + 3'(b) > 3) : (k == 3) ? (b >= a) :
          (k == 4) ? (a != b) : (a >= b);
        repeat (4) @(posedge clk);
        #1;
        chk({31'h0, fastCarryOut}, {31'h0, e});
        if (k < 2 || k == 5)
        begin
          pulse(3'h4);
          chk({registerOutOne[2], registerOutZero[2]},
            k ? 2'(a - b) : 2'(a + b));
        end
      end
    end
    // counter with sync preload, then up and down counts
    wr(tile_pkg::MODE_OFFSET, 32'h1015 | (32'(tile_pkg::OP_UP) << 8));
    @(posedge clk);
    neighbourCarry <= 1'b1;
    multipurposeInZero <= 4'h1;
    multipurposeInOne <= 4'h0;
    localSetReset <= 3'h1;
    pulse(3'h1);
    chk({registerOutOne[0], registerOutZero[0]}, 32'h1);
    localSetReset <= 3'h0;
    repeat (6) pulse(3'h1);
    chk({registerOutOne[0], registerOutZero[0]}, 32'h3);
    wr(tile_pkg::MODE_OFFSET, 32'h0015 | (32'(tile_pkg::OP_DOWN) << 8));
    neighbourCarry <= 1'b0;
    repeat (2) pulse(3'h1);
    chk({registerOutOne[0], registerOutZero[0]}, 32'h1);
    $display("test ripple done");
    // lut ram written from slice 2, read on own inputs
    wr(tile_pkg::MODE_OFFSET, 32'h2A);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      lutDataIn <= {8'h0, ramData[i % 3] ^ {4{i == 3}}, ramAddr[i % 3], 16'h0};
      multipurposeInZero <= (i == 3) ? 4'h0 : 4'h4;
      localSetReset <= 3'h4;
      pulse(3'h4);
      localSetReset <= 3'h0;
      lutDataIn <= {16'h0, {4{ramAddr[i % 3]}}};
      repeat (3) @(posedge clk);
      #1;
      chk({lutBypassOutOne[1], lutBypassOutZero[1], lutBypassOutOne[0],
        lutBypassOutZero[0]}, ramData[i % 3]);
    end
    // pseudo dual-port: slice 0 reads at the write address
    wr(tile_pkg::MODE_OFFSET, 32'h1_002A);
    @(posedge clk);
    lutDataIn <= {8'h0, 4'h2, 4'h9, 16'h0};
    multipurposeInZero <= 4'h4;
    localSetReset <= 3'h4;
    pulse(3'h4);
    localSetReset <= 3'h0;
    lutDataIn <= {12'h0, 4'h9, 8'h99, 8'h0};
    repeat (3) @(posedge clk);
    #1;
    chk({lutBypassOutOne[1], lutBypassOutZero[1], lutBypassOutOne[0],
      lutBypassOutZero[0]}, 32'hA);
    // rom mode refuses a write attempt from slice 2
    wr(tile_pkg::MODE_OFFSET, 32'h3F);
    @(posedge clk);
    lutDataIn <= 32'h0;
    localSetReset <= 3'h4;
    pulse(3'h4);
    localSetReset <= 3'h0;
    rdchk(8'h00, 32'h0000_0001);
    $display("test ram done");
    summarize();
  end
endmodule
